// ==== clock_mode_defines.svh ====
// Register offsets, field positions, reset values and timing counts of the clock mode block.
`ifndef CLOCK_MODE_DEFINES_SVH
`define CLOCK_MODE_DEFINES_SVH

// Byte addresses of the five control registers (one aligned word each).
`define SCC_OFF 12'h000
`define HRC_OFF 12'h004
`define HXC_OFF 12'h008
`define LXC_OFF 12'h00c
`define PLC_OFF 12'h010

// Reset values of the control registers.
`define SCC_RST 8'h40
`define HRC_RST 8'h01
`define HXC_RST 8'h00
`define LXC_RST 8'h00
`define PLC_RST 8'h01

// Writable bit masks; every other bit ignores writes and reads zero, except bit 1 of the oscillator registers, which reads the ready flag.
`define SCC_WMASK 8'hef
`define HRC_WMASK 8'he1
`define HXC_WMASK 8'h05
`define LXC_WMASK 8'h01
`define PLC_WMASK 8'hbd

// Field positions.
`define SCC_DIV_LSB 5
`define SCC_HFSEL 3
`define SCC_LFSEL 2
`define SCC_HFKEEP 1
`define SCC_LFKEEP 0
`define HRC_TRIM_EN 7
`define HRC_LOCKED 6
`define HRC_FREEZE 5
`define RDY_BIT 1
`define EN_BIT 0
`define HXC_RANGE 2
`define PLC_INSEL 5
`define PLC_SRC_LSB 2

// Code of the low-speed system clock choice.
`define DIV_SUB 3'h7

// Settling times in microseconds and their cycle counts at 20 MHz.
`define CLK_MHZ 20
`define RC_SETTLE_US 16
`define XT_SETTLE_US 128
`define PLL_SETTLE_US 64
`define RC_SETTLE_CYC (`RC_SETTLE_US * `CLK_MHZ)
`define XT_SETTLE_CYC (`XT_SETTLE_US * `CLK_MHZ)
`define PLL_SETTLE_CYC (`PLL_SETTLE_US * `CLK_MHZ)

`endif

// ==== clock_mode_pkg.sv ====
// Types shared by the clock mode block.
package clock_mode_pkg;
    // Standby state of the core.
    typedef enum logic [2:0] {
        RUN_MODE,
        SLEEP_MODE,
        STANDBY_LF_ONLY,
        STANDBY_HF_ONLY,
        STANDBY_BOTH_OSC
    } power_mode_t;
    // Source sequencer index.
    typedef enum logic [1:0] {
        SRC_RC,
        SRC_HXT,
        SRC_LXT,
        SRC_PLL
    } src_idx_t;
endpackage : clock_mode_pkg

// ==== system_clock_mode_control.sv ====
// System clock selection, oscillator enables and standby control with an APB slave.
//
// Operation
// - Halt with both keeps: both oscillators run
// - Halt with high keep only: high runs
// - Codes 0-6 divide fH, 7 selects fSUB
// - High source: 0 internal RC, 1 crystal
// - Low source: 0 low RC, 1 crystal
// - High keep bit keeps fast oscillator running in halt
// - Low keep 0 still enables watchdog clock
// - Trim locked flag set, software may clear
// - Freeze holds trimmed RC frequency when locked
// - RC enable clears ready until stable
// - Unimplemented bits read zero, ignore writes
// - Crystal range ignored while crystal enabled
// - Crystal enable clears ready until stable
// - Low crystal enable clears ready until stable
// - PLL input 0 halves 12 MHz, 1 direct
// - Internal RC source forces PLL input zero
// - PLL enable clears ready until stable
// - Halt with no keeps: sleep, watchdog optional
// - Halt with low keep only: low runs
//
// The APB register port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`include "clock_mode_defines.svh"

module system_clock_mode_control
    import clock_mode_pkg::*;
(
    // Clock and reset.
    input wire logic clk,
    input wire logic rst,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Core and watchdog status.
    input wire logic halt_exec,
    input wire logic wake_event,
    input wire logic wdt_enabled,
    input wire logic rc_trim_in_range,
    // Oscillator and PLL controls.
    output logic int_rc_run,
    output logic hf_crystal_run,
    output logic lf_crystal_run,
    output logic int_lf_rc_run,
    output logic pll_run,
    output logic crystal_range_sel,
    output logic pll_in_freq_sel,
    output logic pll_in_div2,
    output logic [1:0] pll_rate_sel,
    output logic fh_from_pll,
    output logic hf_src_sel,
    output logic lf_src_sel,
    output logic [2:0] sys_clk_div_sel,
    output logic sys_clk_is_sub,
    output logic cpu_clk_run,
    output logic fh_run,
    output logic fsub_run,
    output logic wdt_clk_run,
    output logic rc_trim_active,
    output logic rc_trim_hold,
    output logic [2:0] power_mode
);

    // Register storage.
    logic [7:0] scc_reg;
    logic [7:0] hrc_reg;
    logic [7:0] hxc_reg;
    logic [7:0] lxc_reg;
    logic [7:0] plc_reg;
    // Ready flags, one per source, indexed by src_idx_t.
    logic [3:0] ready_reg;
    // Standby state.
    power_mode_t mode_reg;
    // Bus phase qualifiers: writes in the access phase, reads in the setup phase.
    logic wr_acc;
    logic rd_acc;
    // Source enables gathered for the settle counters.
    logic [3:0] src_en;
    // Settle counter at its limit, one bit per source.
    logic [3:0] settle_done;
    // One-hot register select of the current address.
    // It is decoded once for the read mux and every register write; pslverr uses its own decode.
    // A function result cannot be indexed, so this net carries it.
    logic [4:0] hit;

    // Decode the address into a one-hot register select.
    function automatic logic [4:0] reg_hit(input logic [11:0] addr);
        reg_hit = 5'h00;
        unique case (addr)
            `SCC_OFF: reg_hit = 5'h01;
            `HRC_OFF: reg_hit = 5'h02;
            `HXC_OFF: reg_hit = 5'h04;
            `LXC_OFF: reg_hit = 5'h08;
            `PLC_OFF: reg_hit = 5'h10;
            default: reg_hit = 5'h00;
        endcase
    endfunction : reg_hit

    // Merge a write into a register keeping only implemented bits.
    function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] wd,
                                         input logic [7:0] msk);
        merge = (old & ~msk) | (wd & msk);
    endfunction : merge

    // A write takes effect at the access phase edge; the slave answers with no wait.
    assign wr_acc = psel && penable && pwrite;
    assign rd_acc = psel && !penable && !pwrite;

    // Address decode shared by the read mux and all write paths.
    // An unmapped address leaves every bit low, so no register changes.
    assign hit = reg_hit(paddr);

    assign src_en = {plc_reg[`EN_BIT], lxc_reg[`EN_BIT], hxc_reg[`EN_BIT], hrc_reg[`EN_BIT]};

    // APB answer: always ready, error on an unmapped address.
    always_ff @(posedge clk) begin
        if (rst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && (reg_hit(paddr) == 5'h00);
        end
    end

    // Read data is captured in the setup cycle so it is a flop output at the access edge.
    always_ff @(posedge clk) begin
        if (rst) begin
            prdata <= 32'h00000000;
        end else if (rd_acc) begin
            // The ready flags replace bit 1 of each oscillator register.
            // Unimplemented bits are stored as zero, so they read zero.
            unique case (1'b1)
                hit[0]: prdata <= {24'h000000, scc_reg};
                hit[1]: prdata <= {24'h000000, hrc_reg[7:2], ready_reg[SRC_RC], hrc_reg[0]};
                hit[2]: prdata <= {24'h000000, hxc_reg[7:2], ready_reg[SRC_HXT], hxc_reg[0]};
                hit[3]: prdata <= {24'h000000, lxc_reg[7:2], ready_reg[SRC_LXT], lxc_reg[0]};
                hit[4]: prdata <= {24'h000000, plc_reg[7:2], ready_reg[SRC_PLL], plc_reg[0]};
                // An unmapped read returns zero alongside the error.
                default: prdata <= 32'h00000000;
            endcase
        end
    end

    // System clock control register; only implemented bits are kept.
    always_ff @(posedge clk) begin
        if (rst) begin
            scc_reg <= `SCC_RST;
        end else if (wr_acc && hit[0]) begin
            // Bit 4 is masked out, so it always stays zero.
            scc_reg <= merge(scc_reg, pwdata[7:0], `SCC_WMASK);
        end
    end

    // Internal RC control; the locked flag is set by hardware and cleared by software.
    // A set arriving in the clearing cycle wins so a lock event is never lost.
    always_ff @(posedge clk) begin
        if (rst) begin
            hrc_reg <= `HRC_RST;
        end else begin
            // Software owns the trim enable, the freeze and the enable bit.
            if (wr_acc && hit[1]) begin
                hrc_reg[7] <= pwdata[7];
                hrc_reg[5] <= pwdata[5];
                hrc_reg[0] <= pwdata[0];
                hrc_reg[4:1] <= 4'h0;
            end
            if (hrc_reg[`HRC_TRIM_EN] && ready_reg[SRC_RC] && rc_trim_in_range) begin
                hrc_reg[`HRC_LOCKED] <= 1'b1;
            end else if (wr_acc && hit[1] && !pwdata[`HRC_LOCKED]) begin
                // Writing one to the flag leaves it as it is.
                hrc_reg[`HRC_LOCKED] <= 1'b0;
            end
        end
    end

    // High-speed crystal control; range is frozen while the crystal is enabled.
    always_ff @(posedge clk) begin
        if (rst) begin
            hxc_reg <= `HXC_RST;
        end else if (wr_acc && hit[2]) begin
            hxc_reg[`EN_BIT] <= pwdata[`EN_BIT];
            // The old enable decides, so a write that clears the enable cannot also
            // change the range under a running crystal.
            if (!hxc_reg[`EN_BIT]) begin
                hxc_reg[`HXC_RANGE] <= pwdata[`HXC_RANGE];
            end
        end
    end

    // Low-speed crystal control.
    always_ff @(posedge clk) begin
        if (rst) begin
            lxc_reg <= `LXC_RST;
        end else if (wr_acc && hit[3]) begin
            // Only the enable bit is stored here.
            lxc_reg <= merge(lxc_reg, pwdata[7:0], `LXC_WMASK);
        end
    end

    // PLL control; the input select is forced to zero while the internal RC is chosen.
    always_ff @(posedge clk) begin
        if (rst) begin
            plc_reg <= `PLC_RST;
        end else begin
            // The reserved top bit is plain storage; software must leave it zero.
            if (wr_acc && hit[4]) begin
                plc_reg <= merge(plc_reg, pwdata[7:0], `PLC_WMASK);
            end
            // The force comes last, so it wins over a write in the same cycle.
            if (!scc_reg[`SCC_HFSEL]) begin
                plc_reg[`PLC_INSEL] <= 1'b0;
            end
        end
    end

    // One settle counter per source; the analog parts are modelled by fixed start-up times.
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_settle
            localparam int unsigned LIMIT = (gi == SRC_PLL) ? `PLL_SETTLE_CYC :
                                            (gi == SRC_RC) ? `RC_SETTLE_CYC : `XT_SETTLE_CYC;
            // Cycles counted since the source was enabled.
            logic [12:0] cnt_reg;
            // Ready flag of this source; each bank owns its own flop.
            logic rdy_reg;
            // Counting restarts whenever the source is off, so re-enabling re-arms the wait.
            always_ff @(posedge clk) begin
                if (rst || !src_en[gi]) begin
                    cnt_reg <= 13'h0000;
                end else if (cnt_reg != 13'(LIMIT)) begin
                    cnt_reg <= cnt_reg + 13'h0001;
                end
            end
            assign settle_done[gi] = src_en[gi] && (cnt_reg == 13'(LIMIT));
            // Ready falls on disable and rises only after the settle time.
            // A re-enable restarts from zero, so the flag reads zero first.
            always_ff @(posedge clk) begin
                if (rst) begin
                    rdy_reg <= 1'b0;
                end else begin
                    rdy_reg <= settle_done[gi];
                end
            end
            // Gather the flags into one vector for the read mux.
            assign ready_reg[gi] = rdy_reg;
        end
    endgenerate

    // Standby state: halt picks the mode from the keep bits, a wake returns to run.
    always_ff @(posedge clk) begin
        if (rst) begin
            mode_reg <= RUN_MODE;
        end else if (mode_reg != RUN_MODE) begin
            if (wake_event) begin
                mode_reg <= RUN_MODE;
            end
        end else if (halt_exec) begin
            // The keep bits are read at the halt, not while halted.
            unique case ({scc_reg[`SCC_HFKEEP], scc_reg[`SCC_LFKEEP]})
                2'b11: mode_reg <= STANDBY_BOTH_OSC;
                2'b10: mode_reg <= STANDBY_HF_ONLY;
                2'b01: mode_reg <= STANDBY_LF_ONLY;
                2'b00: mode_reg <= SLEEP_MODE;
            endcase
        end
    end

    // Clock tree and oscillator outputs, all registered.
    always_ff @(posedge clk) begin
        if (rst) begin
            int_rc_run <= 1'b0;
            hf_crystal_run <= 1'b0;
            lf_crystal_run <= 1'b0;
            int_lf_rc_run <= 1'b0;
            pll_run <= 1'b0;
            crystal_range_sel <= 1'b0;
            pll_in_freq_sel <= 1'b0;
            pll_in_div2 <= 1'b0;
            pll_rate_sel <= 2'h0;
            fh_from_pll <= 1'b0;
            hf_src_sel <= 1'b0;
            lf_src_sel <= 1'b0;
            sys_clk_div_sel <= 3'h0;
            sys_clk_is_sub <= 1'b0;
            cpu_clk_run <= 1'b0;
            fh_run <= 1'b0;
            fsub_run <= 1'b0;
            wdt_clk_run <= 1'b0;
            rc_trim_active <= 1'b0;
            rc_trim_hold <= 1'b0;
            power_mode <= 3'h0;
        end else begin
            // The fast oscillator stops in standby unless its keep bit is set.
            fh_run <= (mode_reg == RUN_MODE) || (mode_reg == STANDBY_BOTH_OSC) ||
                      (mode_reg == STANDBY_HF_ONLY);
            fsub_run <= (mode_reg == RUN_MODE) || (mode_reg == STANDBY_BOTH_OSC) ||
                        (mode_reg == STANDBY_LF_ONLY);
            // Watchdog clock survives a cleared low keep bit when the watchdog is on.
            wdt_clk_run <= fsub_run_next() || wdt_enabled;
            // The core clock only runs outside standby.
            cpu_clk_run <= (mode_reg == RUN_MODE);
            // Fast sources follow their enables and the fast keep decision.
            int_rc_run <= hrc_reg[`EN_BIT] && fh_keep_next();
            hf_crystal_run <= hxc_reg[`EN_BIT] && fh_keep_next();
            pll_run <= plc_reg[`EN_BIT] && fh_keep_next();
            // The slow crystal is left to its enable, as slow clocks cost little.
            lf_crystal_run <= lxc_reg[`EN_BIT];
            int_lf_rc_run <= !scc_reg[`SCC_LFSEL] || wdt_enabled;
            // Static selections are passed on one cycle after the write.
            crystal_range_sel <= hxc_reg[`HXC_RANGE];
            hf_src_sel <= scc_reg[`SCC_HFSEL];
            lf_src_sel <= scc_reg[`SCC_LFSEL];
            sys_clk_div_sel <= scc_reg[7:5];
            sys_clk_is_sub <= (scc_reg[7:5] == `DIV_SUB);
            pll_in_freq_sel <= plc_reg[`PLC_INSEL];
            pll_in_div2 <= !plc_reg[`PLC_INSEL];
            fh_from_pll <= plc_reg[4];
            pll_rate_sel <= plc_reg[3:2];
            // A frozen trim stops the loop from pulling the RC any further.
            rc_trim_active <= hrc_reg[`HRC_TRIM_EN] && !rc_trim_hold_next();
            rc_trim_hold <= rc_trim_hold_next();
            power_mode <= mode_reg;
        end
    end

    // Next-state helpers; all but fsub_run_next are shared by several outputs.
    // Fast sources may run now or in a standby that keeps them.
    function automatic logic fh_keep_next();
        fh_keep_next = (mode_reg == RUN_MODE) || (mode_reg == STANDBY_BOTH_OSC) ||
                       (mode_reg == STANDBY_HF_ONLY);
    endfunction : fh_keep_next

    // The slow clock runs now or in a standby that keeps it.
    function automatic logic fsub_run_next();
        fsub_run_next = (mode_reg == RUN_MODE) || (mode_reg == STANDBY_BOTH_OSC) ||
                        (mode_reg == STANDBY_LF_ONLY);
    endfunction : fsub_run_next

    // Freezing only takes hold once the trim has locked.
    function automatic logic rc_trim_hold_next();
        rc_trim_hold_next = hrc_reg[`HRC_FREEZE] && hrc_reg[`HRC_LOCKED];
    endfunction : rc_trim_hold_next

endmodule : system_clock_mode_control

// ==== clock_mode_asserts.sv ====
// Concurrent checks on the ports of the clock mode block.
`timescale 1ns/1ps
module clock_mode_asserts
    import clock_mode_pkg::*;
(
    // Clock and reset.
    input wire logic clk,
    input wire logic rst,
    // Bus.
    input wire logic psel,
    input wire logic penable,
    input wire logic [11:0] paddr,
    input wire logic pready,
    input wire logic pslverr,
    // Clock status.
    input wire logic wdt_enabled,
    input wire logic hf_src_sel,
    input wire logic pll_in_freq_sel,
    input wire logic pll_in_div2,
    input wire logic [2:0] sys_clk_div_sel,
    input wire logic sys_clk_is_sub,
    input wire logic cpu_clk_run,
    input wire logic fh_run,
    input wire logic fsub_run,
    input wire logic wdt_clk_run,
    input wire logic [2:0] power_mode
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // A setup cycle is answered in the next cycle, for one cycle only.
    property p_ready;
        psel && !penable |=> pready ##1 !pready;
    endproperty
    a_ready: assert property (p_ready) else $error("pready timing wrong");
    // Addresses past the last register answer with an error.
    property p_unmapped;
        psel && !penable && paddr > 12'h010 |=> pready && pslverr;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("no error on unmapped address");
    // Outputs are zero in the first cycle after reset, so these wait one edge.
    property p_sub;
        !$past(rst) |-> sys_clk_is_sub == (sys_clk_div_sel == 3'h7);
    endproperty
    a_sub: assert property (p_sub) else $error("low-speed choice mismatch");
    property p_div2;
        !$past(rst) |-> pll_in_div2 != pll_in_freq_sel;
    endproperty
    a_div2: assert property (p_div2) else $error("PLL halving wrong");
    // Two cycles of the RC choice give the forced clear time to land.
    property p_force;
        !hf_src_sel && !$past(hf_src_sel) |-> !pll_in_freq_sel;
    endproperty
    a_force: assert property (p_force) else $error("PLL input not forced");
    property p_wdt;
        wdt_enabled && $past(wdt_enabled) && !$past(rst) |-> wdt_clk_run;
    endproperty
    a_wdt: assert property (p_wdt) else $error("watchdog clock off");
    // Standby outputs are judged once the mode has held for two edges.
    property p_sleep;
        power_mode == SLEEP_MODE && $past(power_mode) == SLEEP_MODE
            |-> !cpu_clk_run && !fh_run && !fsub_run;
    endproperty
    a_sleep: assert property (p_sleep) else $error("sleep clocks wrong");
    property p_both;
        power_mode == STANDBY_BOTH_OSC && $past(power_mode) == STANDBY_BOTH_OSC
            |-> !cpu_clk_run && fh_run && fsub_run;
    endproperty
    a_both: assert property (p_both) else $error("both-oscillator standby wrong");
    property p_hf;
        power_mode == STANDBY_HF_ONLY && $past(power_mode) == STANDBY_HF_ONLY
            |-> !cpu_clk_run && fh_run && !fsub_run;
    endproperty
    a_hf: assert property (p_hf) else $error("high-speed standby wrong");
    property p_lf;
        power_mode == STANDBY_LF_ONLY && $past(power_mode) == STANDBY_LF_ONLY
            |-> !cpu_clk_run && !fh_run && fsub_run;
    endproperty
    a_lf: assert property (p_lf) else $error("low-speed standby wrong");
    c_err: cover property (pready && pslverr);
    c_sub: cover property (sys_clk_is_sub);
    c_both: cover property (power_mode == STANDBY_BOTH_OSC);
endmodule : clock_mode_asserts

bind system_clock_mode_control clock_mode_asserts chk_u (.clk(clk), .rst(rst),
    .psel(psel), .penable(penable), .paddr(paddr), .pready(pready), .pslverr(pslverr),
    .wdt_enabled(wdt_enabled), .hf_src_sel(hf_src_sel), .pll_in_freq_sel(pll_in_freq_sel),
    .pll_in_div2(pll_in_div2), .sys_clk_div_sel(sys_clk_div_sel),
    .sys_clk_is_sub(sys_clk_is_sub), .cpu_clk_run(cpu_clk_run), .fh_run(fh_run),
    .fsub_run(fsub_run), .wdt_clk_run(wdt_clk_run), .power_mode(power_mode));

// ==== core_osc_model.sv ====
// Behavioural model of the halting core and the RC trim loop.
`timescale 1ns/1ps
module core_osc_model (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst,
    // Bench commands.
    input wire logic go_halt,
    input wire logic go_wake,
    // Block outputs seen by the core.
    input wire logic cpu_clk_run,
    input wire logic int_rc_run,
    input wire logic rc_trim_active,
    // Status back to the block.
    output logic halt_exec = 1'b0,
    output logic wake_event = 1'b0,
    output logic rc_trim_in_range = 1'b0
);
    logic [3:0] lock_cnt = 4'h0; // Cycles the trim loop has been pulling.
    // A stopped core cannot execute halt, and a running one has nothing to wake.
    always @(posedge clk) begin
        halt_exec <= go_halt && cpu_clk_run && !rst;
        wake_event <= go_wake && !cpu_clk_run && !rst;
    end
    // The loop needs a running RC and several cycles before it is in range.
    always @(posedge clk) begin
        if (rst || !int_rc_run || !rc_trim_active) begin
            lock_cnt <= 4'h0;
        end else if (lock_cnt != 4'h8) begin
            lock_cnt <= lock_cnt + 4'h1;
        end
        rc_trim_in_range <= lock_cnt == 4'h8;
    end
endmodule : core_osc_model

// ==== system_clock_mode_control_tb.sv ====
// Self-checking bench for the clock mode block.
`timescale 1ns/1ps
`include "clock_mode_defines.svh"
module system_clock_mode_control_tb
    import clock_mode_pkg::*;
();
    localparam logic [11:0] AD [5] = '{`SCC_OFF, `HRC_OFF, `HXC_OFF, `LXC_OFF, `PLC_OFF};
    localparam logic [7:0] RV [5] = '{8'h40, 8'h01, 8'h00, 8'h00, 8'h01};
    localparam logic [7:0] EV [4] = '{8'h01, 8'h05, 8'h01, 8'h01};
    localparam int ST [4] = '{`RC_SETTLE_CYC, `XT_SETTLE_CYC, `XT_SETTLE_CYC, `PLL_SETTLE_CYC};
    localparam logic [2:0] MD [4] = '{SLEEP_MODE, STANDBY_LF_ONLY, STANDBY_HF_ONLY,
        STANDBY_BOTH_OSC};
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd_q;
    logic pready, pslverr, err_q, halt_exec, wake_event, rc_trim_in_range;
    logic wdt_enabled = 1'b0, go_halt = 1'b0, go_wake = 1'b0;
    logic int_rc_run, hf_crystal_run, lf_crystal_run, int_lf_rc_run, pll_run, fh_from_pll;
    logic crystal_range_sel, pll_in_freq_sel, pll_in_div2, hf_src_sel, lf_src_sel;
    logic [1:0] pll_rate_sel;
    logic [2:0] sys_clk_div_sel, power_mode;
    logic sys_clk_is_sub, cpu_clk_run, fh_run, fsub_run, wdt_clk_run, rc_trim_active;
    logic rc_trim_hold;
    int num_errors = 0, num_checks = 0, cyc = 0;
    system_clock_mode_control dut_u (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .halt_exec(halt_exec), .wake_event(wake_event),
        .wdt_enabled(wdt_enabled), .rc_trim_in_range(rc_trim_in_range),
        .int_rc_run(int_rc_run), .hf_crystal_run(hf_crystal_run),
        .lf_crystal_run(lf_crystal_run), .int_lf_rc_run(int_lf_rc_run), .pll_run(pll_run),
        .crystal_range_sel(crystal_range_sel), .pll_in_freq_sel(pll_in_freq_sel),
        .pll_in_div2(pll_in_div2), .pll_rate_sel(pll_rate_sel), .fh_from_pll(fh_from_pll),
        .hf_src_sel(hf_src_sel), .lf_src_sel(lf_src_sel), .sys_clk_div_sel(sys_clk_div_sel),
        .sys_clk_is_sub(sys_clk_is_sub), .cpu_clk_run(cpu_clk_run), .fh_run(fh_run),
        .fsub_run(fsub_run), .wdt_clk_run(wdt_clk_run), .rc_trim_active(rc_trim_active),
        .rc_trim_hold(rc_trim_hold), .power_mode(power_mode));
    core_osc_model core_u (.clk(clk), .rst(rst), .go_halt(go_halt), .go_wake(go_wake),
        .cpu_clk_run(cpu_clk_run), .int_rc_run(int_rc_run), .rc_trim_active(rc_trim_active),
        .halt_exec(halt_exec), .wake_event(wake_event), .rc_trim_in_range(rc_trim_in_range));
    // Free-running 50 ns clock.
    initial begin
        forever #25 clk = ~clk;
    end
    // Prints the counts and the verdict, then stops the run.
    task automatic results();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : results
    // A hang would otherwise never reach the verdict.
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            num_errors++;
            $display("unexpected at %0t: timeout", $time);
            results();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // One bus transfer; the request is held until pready is seen at an edge.
    task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        chk(n < 20, 1'b1);
        rd_q = prdata;
        err_q = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : xfer
    task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic [31:0] m);
        xfer(1'b0, a, 32'h0);
        chk(rd_q & m, exp);
    endtask : rd
    // Disables a source, enables it, and watches the ready flag across the settle time.
    task automatic settle(input logic [11:0] a, input logic [7:0] v, input int n);
        xfer(1'b1, a, {24'h0, v & 8'hfe});
        rd(a, {24'h0, v & 8'hfe}, 32'hff);
        xfer(1'b1, a, {24'h0, v});
        rd(a, {24'h0, v}, 32'hff);
        repeat (n - 20) @(posedge clk);
        rd(a, {24'h0, v}, 32'hff);
        repeat (40) @(posedge clk);
        rd(a, {24'h0, v | 8'h02}, 32'hff);
    endtask : settle
    initial begin
        logic [2:0] c;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 5; i++) rd(AD[i], RV[i], 32'hffffffff);
        rd(12'h014, 32'h0, 32'hffffffff);
        chk(err_q, 1'b1);
        xfer(1'b1, `SCC_OFF, 32'hff);
        rd(`SCC_OFF, 32'hef, 32'hffffffff);
        $display("test reset done");
        for (int i = 0; i < 8; i++) begin
            c = i;
            xfer(1'b1, `SCC_OFF, {c, 1'b0, c[0], c[1], 2'b00});
            rd(`SCC_OFF, {c, 1'b0, c[0], c[1], 2'b00}, 32'hff);
            chk(sys_clk_div_sel, c);
            chk(sys_clk_is_sub, c == 3'h7);
            chk(hf_src_sel, c[0]);
            chk(lf_src_sel, c[1]);
        end
        $display("test select done");
        for (int i = 0; i < 4; i++) settle(AD[i + 1], EV[i], ST[i]);
        xfer(1'b1, `HXC_OFF, 32'h01);
        rd(`HXC_OFF, 32'h07, 32'hff);
        chk(crystal_range_sel, 1'b1);
        $display("test ready done");
        xfer(1'b1, `SCC_OFF, 32'h00);
        xfer(1'b1, `PLC_OFF, 32'h21);
        rd(`PLC_OFF, 32'h01, 32'hfd);
        xfer(1'b1, `SCC_OFF, 32'h08);
        for (int i = 0; i < 8; i++) begin
            c = i;
            xfer(1'b1, `PLC_OFF, {2'b00, c[0], c, 2'b01});
            rd(`PLC_OFF, {2'b00, c[0], c, 2'b01}, 32'hfd);
            chk(pll_in_freq_sel, c[0]);
            chk(pll_in_div2, !c[0]);
            chk(fh_from_pll, c[2]);
            chk(pll_rate_sel, c[1:0]);
        end
        $display("test pll done");
        xfer(1'b1, `HRC_OFF, 32'ha1);
        repeat (20) @(posedge clk);
        rd(`HRC_OFF, 32'he1, 32'hfd);
        chk(rc_trim_hold, 1'b1);
        chk(rc_trim_active, 1'b0);
        xfer(1'b1, `HRC_OFF, 32'h01);
        rd(`HRC_OFF, 32'h01, 32'hfd);
        $display("test trim done");
        xfer(1'b1, `SCC_OFF, 32'h00);
        for (int k = 0; k < 4; k++) begin
            c = k;
            wdt_enabled <= (k == 0);
            xfer(1'b1, `SCC_OFF, {30'h0, c[1:0]});
            go_halt <= 1'b1;
            @(posedge clk);
            go_halt <= 1'b0;
            repeat (6) @(posedge clk);
            chk(power_mode, MD[k]);
            chk({cpu_clk_run, fh_run, fsub_run}, {1'b0, c[1:0]});
            chk(wdt_clk_run, c[0] | (k == 0));
            chk({int_rc_run, hf_crystal_run, pll_run, lf_crystal_run}, {{3{c[1]}}, 1'b1});
            chk(int_lf_rc_run, 1'b1);
            go_wake <= 1'b1;
            @(posedge clk);
            go_wake <= 1'b0;
            repeat (6) @(posedge clk);
            chk({power_mode, cpu_clk_run}, 4'h1);
        end
        $display("test standby done");
        results();
    end
endmodule : system_clock_mode_control_tb
